// ### src/cmp_edge_pkg.sv
// constants for the comparator edge flag control block
package cmp_edge_pkg;
  localparam int RegAddrWidth = 4;
  localparam logic [3:0] STATUS_CONTROL_OFFSET = 4'h0;
  localparam logic [3:0] SYSTEM_OPTIONS_OFFSET = 4'h1;
  localparam int ModuleEnableBit = 7;
  localparam int ReferenceSelectBit = 6;
  localparam int CompareFlagBit = 5;
  localparam int IrqEnableBit = 4;
  localparam int OutputStatusBit = 3;
  localparam int OutputPinEnableBit = 2;
  localparam int EventModeHi = 1;
  localparam int EventModeLo = 0;
  localparam int RouteCaptureBit = 0;
  localparam int BufferEnableBit = 1;
  localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SYSTEM_OPTIONS_RESET = 8'h00;
  localparam logic [1:0] MODE_FALL_A = 2'h0;
  localparam logic [1:0] MODE_RISE = 2'h1;
  localparam logic [1:0] MODE_FALL_B = 2'h2;
  localparam logic [1:0] MODE_EITHER = 2'h3;
endpackage

// ### src/cmp_sync_edge.sv
// two flop synchroniser with an edge detector behind it
`timescale 1ns/1ps
`default_nettype none
module cmp_sync_edge
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic asyncIn,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // ------------------------------------------------------------
  // synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= asyncIn & enable;
      sync_q <= meta_q;
    end
  end

  // history follows the gated sync level, so enabling with the input already high reports a rise
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      last_q <= 1'b0;
    else
      last_q <= sync_q;
  end

  assign level = sync_q;
  assign rise = sync_q & ~last_q & enable;
  assign fall = ~sync_q & last_q & enable;
endmodule
`default_nettype wire

// ### src/comparator_edge_flag_control.sv
// control, status and edge flag logic around an analog comparator
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R01: module works only while enable bit set
// R02: reference bit picks positive pin or bandgap
// R03: chosen edge sets compare flag
// R04: writing one clears flag, zero keeps
// R05: interrupt while flag set and enabled
// R06: status bit reads live comparator output
// R07: status bit zero while module disabled
// R08: output pin enable drives comparator pin
// R09: mode 00/10 fall, 01 rise, 11 both
// R10: keeps running during wait mode
// R11: software disables module when wake unneeded
// R12: shallow stop keeps comparing and waking
// R13: shallow stop keeps output pin drive
// R14: reset from stop restores reset values
// R15: deep stop powers down, resets state
// R16: background debug does not freeze anything
// R17: routing bit feeds comparator to capture
// R18: routed timer pin unavailable externally
// R19: software enables bandgap buffer first
// R20: output high when positive input larger
// R21: synchronised input, set beats clear
module comparator_edge_flag_control
  import cmp_edge_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [RegAddrWidth-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic compareRaw,
  output logic referenceSelect,
  output logic analogEnable,
  input wire logic bandgapBufferEnable,
  output logic compareOutPin,
  output logic compareOutPinEn,
  output logic compareIrq,
  input wire logic timerPinIn,
  output logic timerCaptureIn,
  output logic timerPinAvailable
);
  logic moduleEnable_q;
  logic referenceSelect_q;
  logic flag_q;
  logic flag_d;
  logic irqEnable_q;
  logic pinEnable_q;
  logic [1:0] eventMode_q;
  logic route_q;
  logic [7:0] rdData_q;
  logic [7:0] rdData_d;
  logic level;
  logic rise;
  logic fall;
  logic hit;
  logic wrCtrl;
  logic wrSys;

  assign wrCtrl = regWrite && (regAddr == STATUS_CONTROL_OFFSET);
  assign wrSys = regWrite && (regAddr == SYSTEM_OPTIONS_OFFSET);

  // ------------------------------------------------------------
  // comparator output path
  // ------------------------------------------------------------
  // R20: polarity kept as delivered
  // R21: synchronise before edges
  cmp_sync_edge u_sync
  (
    .clk(clk),
    .rst(rst),
    .enable(moduleEnable_q),
    .asyncIn(compareRaw),
    .level(level),
    .rise(rise),
    .fall(fall)
  );

  // R09: edge selection by mode
  always_comb
  begin
    case (eventMode_q)
      MODE_FALL_A: hit = fall;
      MODE_RISE: hit = rise;
      MODE_FALL_B: hit = fall;
      MODE_EITHER: hit = rise | fall;
      default: hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  // R14: every bit back to reset value
  // R15: wake from deep stop arrives as reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      moduleEnable_q <= STATUS_CONTROL_RESET[ModuleEnableBit];
      referenceSelect_q <= STATUS_CONTROL_RESET[ReferenceSelectBit];
      irqEnable_q <= STATUS_CONTROL_RESET[IrqEnableBit];
      pinEnable_q <= STATUS_CONTROL_RESET[OutputPinEnableBit];
      eventMode_q <= STATUS_CONTROL_RESET[EventModeHi:EventModeLo];
    end
    else if (wrCtrl)
    begin
      // R01: enable bit
      moduleEnable_q <= regWrData[ModuleEnableBit];
      // R02: reference select bit
      referenceSelect_q <= regWrData[ReferenceSelectBit];
      irqEnable_q <= regWrData[IrqEnableBit];
      pinEnable_q <= regWrData[OutputPinEnableBit];
      eventMode_q <= regWrData[EventModeHi:EventModeLo];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      route_q <= SYSTEM_OPTIONS_RESET[RouteCaptureBit];
    else if (wrSys)
      route_q <= regWrData[RouteCaptureBit];
  end

  // ------------------------------------------------------------
  // compare flag
  // ------------------------------------------------------------
  // R03: event sets flag
  // R04: write one to clear
  // R21: set wins over clear
  always_comb
  begin
    flag_d = flag_q;
    if (wrCtrl && regWrData[CompareFlagBit])
      flag_d = 1'b0;
    if (hit)
      flag_d = 1'b1;
  end

  // R10: no wait, stop or debug input exists, so nothing halts it
  // R12: shallow stop keeps this clock, so flag still sets
  // R16: no freeze in background mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flag_q <= STATUS_CONTROL_RESET[CompareFlagBit];
    else
      flag_q <= flag_d;
  end

  // R05: interrupt gated by enable
  assign compareIrq = flag_q & irqEnable_q;

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  // R08: output pin drive
  // R13: same path in shallow stop
  assign compareOutPin = pinEnable_q ? level : 1'b0;
  assign compareOutPinEn = pinEnable_q & moduleEnable_q;
  // R19: reference follows bit, buffer is software's job
  assign referenceSelect = referenceSelect_q;
  assign analogEnable = moduleEnable_q;
  // R17: route to capture
  assign timerCaptureIn = route_q ? level : timerPinIn;
  // R18: pin withdrawn while routed
  assign timerPinAvailable = ~route_q;

  // ------------------------------------------------------------
  // read back
  // ------------------------------------------------------------
  always_comb
  begin
    rdData_d = 8'h00;
    if (regAddr == STATUS_CONTROL_OFFSET)
    begin
      rdData_d[ModuleEnableBit] = moduleEnable_q;
      rdData_d[ReferenceSelectBit] = referenceSelect_q;
      rdData_d[CompareFlagBit] = flag_q;
      rdData_d[IrqEnableBit] = irqEnable_q;
      // R06: live level
      // R07: zero while disabled
      rdData_d[OutputStatusBit] = level & moduleEnable_q;
      rdData_d[OutputPinEnableBit] = pinEnable_q;
      rdData_d[EventModeHi:EventModeLo] = eventMode_q;
    end
    else if (regAddr == SYSTEM_OPTIONS_OFFSET)
    begin
      rdData_d[RouteCaptureBit] = route_q;
      // echo of the buffer enable lets software confirm it first
      rdData_d[BufferEnableBit] = bandgapBufferEnable;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdData_q <= 8'h00;
    else if (regRead)
      rdData_q <= rdData_d;
    else
      rdData_q <= 8'h00;
  end

  assign regRdData = rdData_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // R04: clear without event
  chk_flag_clear: assert property (@(posedge clk) disable iff (rst) // R04
    (wrCtrl && regWrData[CompareFlagBit] && !hit) |=> !flag_q)
    else $error("flag not cleared by write one");

  // R21: set beats clear
  chk_set_wins: assert property (@(posedge clk) disable iff (rst) // R21
    hit |=> flag_q)
    else $error("event lost");

  // R05: interrupt follows flag
  chk_irq_gate: assert property (@(posedge clk) disable iff (rst) // R05
    (hit && irqEnable_q && !wrCtrl) |=> compareIrq)
    else $error("interrupt mismatch");

  // R01: no event while off
  chk_off_quiet: assert property (@(posedge clk) disable iff (rst) // R01
    !moduleEnable_q |-> !hit)
    else $error("flag set while disabled");

  // R07: status zero when off
  chk_status_off: assert property (@(posedge clk) disable iff (rst) // R07
    (regRead && !moduleEnable_q && regAddr == STATUS_CONTROL_OFFSET)
    |=> !regRdData[OutputStatusBit])
    else $error("status bit not zero while disabled");

  // R09: rise mode ignores fall
  chk_rise_only: assert property (@(posedge clk) disable iff (rst) // R09
    (eventMode_q == MODE_RISE && fall) |-> !hit)
    else $error("falling edge hit in rise mode");

  // R08: pin drive follows enable
  chk_pin_drive: assert property (@(posedge clk) disable iff (rst) // R08
    !pinEnable_q |-> (!compareOutPinEn && !compareOutPin))
    else $error("pin driven while disabled");

  // R18: timer pin withdrawn
  chk_route_pin: assert property (@(posedge clk) disable iff (rst) // R18
    route_q |-> (!timerPinAvailable && timerCaptureIn == level))
    else $error("routing wrong");

  // R03: flag holds absent clear
  chk_flag_hold: assert property (@(posedge clk) disable iff (rst) // R03
    (flag_q && !wrCtrl) |=> flag_q)
    else $error("flag dropped");

  // R05: no request while disabled
  chk_irq_off: assert property (@(posedge clk) disable iff (rst) // R05
    !irqEnable_q |-> !compareIrq)
    else $error("interrupt raised while disabled");

  // R06: status shows synced level
  chk_status_live: assert property (@(posedge clk) disable iff (rst) // R06
    (regRead && moduleEnable_q && regAddr == STATUS_CONTROL_OFFSET)
    |=> regRdData[OutputStatusBit] == $past(level))
    else $error("status bit not live level");

  // R03: flag reads back
  chk_flag_read: assert property (@(posedge clk) disable iff (rst) // R03
    (regRead && regAddr == STATUS_CONTROL_OFFSET)
    |=> regRdData[CompareFlagBit] == $past(flag_q))
    else $error("flag read back wrong");

  // R04: writing zero keeps flag
  chk_write_zero: assert property (@(posedge clk) disable iff (rst) // R04
    (flag_q && wrCtrl && !regWrData[CompareFlagBit])
    |=> flag_q)
    else $error("flag lost on zero write");

  // R01: enable follows write
  chk_enable_write: assert property (@(posedge clk) disable iff (rst) // R01
    wrCtrl
    |=> analogEnable == $past(regWrData[ModuleEnableBit]))
    else $error("enable bit not taken");

  // R02: reference follows write
  chk_ref_write: assert property (@(posedge clk) disable iff (rst) // R02
    wrCtrl
    |=> referenceSelect == $past(regWrData[ReferenceSelectBit]))
    else $error("reference bit not taken");

  // R09: fall modes ignore rise
  chk_fall_modes: assert property (@(posedge clk) disable iff (rst) // R09
    ((eventMode_q == MODE_FALL_A || eventMode_q == MODE_FALL_B) && rise)
    |-> !hit)
    else $error("rising edge hit in fall mode");

  // R09: either mode takes both
  chk_either_mode: assert property (@(posedge clk) disable iff (rst) // R09
    (eventMode_q == MODE_EITHER && (rise || fall)) |-> hit)
    else $error("edge missed in either mode");

  // R09: rise mode takes rise
  chk_rise_sets: assert property (@(posedge clk) disable iff (rst) // R09
    (eventMode_q == MODE_RISE && rise) |-> hit)
    else $error("rising edge missed");

  // R08: pin carries the level
  chk_pin_on: assert property (@(posedge clk) disable iff (rst) // R08
    (pinEnable_q && moduleEnable_q)
    |-> (compareOutPinEn && compareOutPin == level))
    else $error("pin not driven with level");

  // R17: pin feeds capture unrouted
  chk_route_off: assert property (@(posedge clk) disable iff (rst) // R17
    !route_q
    |-> (timerPinAvailable && timerCaptureIn == timerPinIn))
    else $error("capture input not from pin");

  // R07: level cleared while off
  chk_off_level: assert property (@(posedge clk) disable iff (rst) // R07
    (!moduleEnable_q && $past(!moduleEnable_q))
    |=> !level)
    else $error("level seen while disabled");

  // R14: reset restores values
  chk_reset_state: assert property (@(posedge clk) // R14
    rst |=> (!moduleEnable_q && !flag_q && !route_q && regRdData == 8'h00))
    else $error("state not reset");

  cov_rise: cover property (@(posedge clk) disable iff (rst)
    eventMode_q == MODE_RISE && rise ##1 flag_q);
  cov_both: cover property (@(posedge clk) disable iff (rst)
    eventMode_q == MODE_EITHER && fall);
  cov_clear_race: cover property (@(posedge clk) disable iff (rst)
    hit && wrCtrl && regWrData[CompareFlagBit]);
  cov_irq: cover property (@(posedge clk) disable iff (rst) compareIrq);
  cov_route: cover property (@(posedge clk) disable iff (rst)
    route_q && level);
endmodule
`default_nettype wire

// ### bench/cmp_analog_model.sv
// behavioural analog front end standing in for the comparator core
`timescale 1ns/1ps
`default_nettype none
module cmp_analog_model
(
  input wire logic analogEnable,
  input wire logic referenceSelect,
  input wire logic bandgapBufferEnable,
  input wire logic [7:0] posMv,
  input wire logic [7:0] negMv,
  input wire logic [7:0] bandgapMv,
  output logic compareRaw
);
  logic [7:0] plusIn;
  // reference mux
  // no buffer means no bandgap voltage, so a careless select reads low
  assign plusIn = !referenceSelect ? posMv :
    (bandgapBufferEnable ? bandgapMv : 8'h00);
  // output high when plus exceeds minus, low while powered off
  assign compareRaw = analogEnable && (plusIn > negMv);
endmodule
`default_nettype wire

// ### bench/comparator_edge_flag_control_tb_top.sv
// self-checking bench for the comparator edge flag control block
`timescale 1ns/1ps
`default_nettype none
module comparator_edge_flag_control_tb_top import cmp_edge_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [RegAddrWidth-1:0] regAddr = '0;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic bgBuf = 1'b0;
  logic timerPinIn = 1'b1;
  logic [7:0] posMv = 8'h0A;
  logic [7:0] regRdData;
  logic compareRaw, referenceSelect, analogEnable, compareOutPin;
  logic compareOutPinEn, compareIrq, timerCaptureIn, timerPinAvailable;
  int errTotal = 0;
  int numChecks = 0;
  always #5 clk = ~clk;
  cmp_analog_model analog (.analogEnable(analogEnable),
    .referenceSelect(referenceSelect), .bandgapBufferEnable(bgBuf),
    .posMv(posMv), .negMv(8'h64), .bandgapMv(8'h96),
    .compareRaw(compareRaw));
  comparator_edge_flag_control dut (.clk(clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .compareRaw(compareRaw),
    .referenceSelect(referenceSelect), .analogEnable(analogEnable),
    .bandgapBufferEnable(bgBuf), .compareOutPin(compareOutPin),
    .compareOutPinEn(compareOutPinEn), .compareIrq(compareIrq),
    .timerPinIn(timerPinIn), .timerCaptureIn(timerCaptureIn),
    .timerPinAvailable(timerPinAvailable));
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      errTotal++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask
  // two sync edges plus the flag edge, with margin
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // analog input changes on a clock edge like every other stimulus
  task automatic drive_pos(input logic [7:0] v);
    @(posedge clk);
    posMv <= v;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic test_reset();
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'hF, 8'h00);
    chk({timerPinAvailable, timerCaptureIn}, 8'h03);
    $display("reset test done");
  endtask
  task automatic test_modes();
    logic [7:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m = i[7:0];
      drive_pos(8'h0A);
      wr(4'h0, 8'hB0 | m);
      settle();
      drive_pos(8'hC8);
      settle();
      rd(4'h0, 8'h98 | m | ((m[0]) ? 8'h20 : 8'h00));
      chk(compareIrq, m[0]);
      wr(4'h0, 8'hB0 | m);
      rd(4'h0, 8'h98 | m);
      drive_pos(8'h0A);
      settle();
      rd(4'h0, 8'h90 | m | ((m != 1) ? 8'h20 : 8'h00));
      wr(4'h0, 8'h90 | m);
      rd(4'h0, 8'h90 | m | ((m != 1) ? 8'h20 : 8'h00));
      wr(4'h0, 8'h80 | m | 8'h20);
      #1;
      chk(compareIrq, 1'b0);
    end
    $display("mode test done");
  endtask
  task automatic test_race();
    wr(4'h0, 8'hB1);
    drive_pos(8'hC8);
    @(posedge clk);
    wr(4'h0, 8'hB1);
    rd(4'h0, 8'hB9);
    chk(compareIrq, 1'b1);
    wr(4'h0, 8'hA1);
    rd(4'h0, 8'h89);
    $display("set and clear race test done");
  endtask
  task automatic test_pin_ref();
    wr(4'h0, 8'h84);
    posMv <= 8'hC8;
    settle();
    chk({compareOutPinEn, compareOutPin, analogEnable}, 8'h07);
    wr(4'h0, 8'h80);
    #1;
    chk({compareOutPinEn, compareOutPin}, 8'h00);
    // buffer on before the bandgap is chosen
    @(posedge clk);
    bgBuf <= 1'b1;
    rd(4'h1, 8'h02);
    wr(4'h0, 8'hC0);
    posMv <= 8'h0A;
    settle();
    rd(4'h0, 8'hC8);
    chk(referenceSelect, 1'b1);
    $display("pin and reference test done");
  endtask
  task automatic test_route_off();
    @(posedge clk);
    timerPinIn <= 1'b0;
    wr(4'h1, 8'h01);
    settle();
    chk({timerPinAvailable, timerCaptureIn}, 8'h01);
    rd(4'h1, 8'h03);
    drive_pos(8'hC8);
    wr(4'h0, 8'h00);
    settle();
    rd(4'h0, 8'h00);
    chk({timerCaptureIn, analogEnable}, 8'h00);
    wr(4'h0, 8'hB3);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h02);
    $display("route, disable and reset test done");
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_modes();
    test_race();
    test_pin_ref();
    test_route_off();
    test_done();
  end
  // the tests need well under 2000 cycles
  initial
  begin
    #50000;
    errTotal++;
    test_done();
  end
endmodule
`default_nettype wire
